// [icu_capture.v]
/*
 * input capture unit with an avalon-mm register slave.
 * holds the pin synchroniser, the edge and prescale qualification,
 * the capture value register, the sticky event flag with its clear
 * and enable registers, and the level interrupt output.
 * assumes timer counts arrive synchronous to i_clock and that the
 * capture pin is asynchronous.
 * assumes the bus master holds each request until waitrequest is low;
 * every request takes two cycles, so back to back requests are legal.
 */
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "icu_map.vh"

module icu_capture #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire i_clock,
    input wire i_rst,
    // avalon-mm slave
    input wire [5:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // timers and pin
    input wire [WIDTH-1:0] i_first_timer_count,
    input wire [WIDTH-1:0] i_third_timer_count,
    input wire i_capture_input_pin,
    // interrupt
    output wire o_irq
);

    // ****************************************
    // decode helpers
    // ****************************************
    function is_capture;
        input [3:0] mode;
        begin
            is_capture = (mode[3:2] == 2'b01);
        end
    endfunction

    function is_prescaled;
        input [3:0] mode;
        begin
            is_prescaled = is_capture(mode) && mode[1];
        end
    endfunction

    function is_word;
        input [3:0] w;
        input [3:0] a;
        begin
            is_word = (w == a);
        end
    endfunction

    // ****************************************
    // registers
    // ****************************************
    reg [3:0] capture_mode_select;
    reg timer_select;
    reg [WIDTH-1:0] capture_value_pair;
    reg capture_event_flag;
    reg capture_irq_enable;
    reg [3:0] prescale_count;
    reg [1:0] pin_sync;
    reg pin_prev;
    reg ack;

    reg [3:0] next_mode;
    reg next_timer_select;
    reg next_irq_enable;
    reg [WIDTH-1:0] next_value;
    reg next_flag;
    reg [3:0] next_prescale;
    reg [31:0] next_readdata;
    reg next_ack;

    // ****************************************
    // bus decode
    // ****************************************
    wire [3:0] word = i_avs_address[5:2];
    wire request = i_avs_read || i_avs_write;
    // read data load in the first cycle so they stand when waitrequest drops;
    // writes commit in the second, at the edge the master sees the answer
    wire access = request && !ack;
    wire rd = i_avs_read && access;
    wire wr = i_avs_write && ack;

    // one wait state: request is taken at the edge where ack is high
    assign o_avs_waitrequest = request && !ack;

    wire ctrl_wr = wr && is_word(word, `ICU_ADDR_CONTROL);
    wire tsel_wr = wr && is_word(word, `ICU_ADDR_TIMER3_CTRL);
    wire enable_wr = wr && is_word(word, `ICU_ADDR_ENABLE);
    wire clear_wr = wr && is_word(word, `ICU_ADDR_CLEAR) && i_avs_writedata[0];
    wire [3:0] new_mode = i_avs_writedata[`ICU_MODE_MSB:0];

    // ****************************************
    // pin synchroniser and edge detection
    // ****************************************
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pin_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], i_capture_input_pin};
        end
    end

    // only the second stage feeds the edge detector
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= pin_sync[1];
        end
    end

    wire rise = pin_sync[1] && !pin_prev;
    wire fall = !pin_sync[1] && pin_prev;

    // ****************************************
    // event qualification
    // ****************************************
    // ****************************************
    // prescale limit
    // ****************************************
    // the 4th or 16th rise captures, so the count runs 0..3 or 0..15
    wire [3:0] limit = (capture_mode_select == `ICU_MODE_RISE16) ?
        `ICU_PRESCALE_16 : `ICU_PRESCALE_4;
    reg qualify;

    always @* begin
        case (capture_mode_select)
            `ICU_MODE_FALL: begin
                qualify = fall;
            end
            `ICU_MODE_RISE: begin
                qualify = rise;
            end
            `ICU_MODE_RISE4,
            `ICU_MODE_RISE16: begin
                qualify = rise && (prescale_count >= limit);
            end
            default: begin
                qualify = 1'b0;
            end
        endcase
    end

    // mode change glitch: any switch from one capture mode to a different capture mode looks like an edge
    wire mode_glitch = ctrl_wr && is_capture(new_mode)
        && (new_mode != capture_mode_select)
        && is_capture(capture_mode_select);

    // ****************************************
    // prescaler counter
    // ****************************************
    always @* begin
        next_prescale = prescale_count;
        if (!is_prescaled(capture_mode_select)) begin
            next_prescale = 4'h0;
        end else if (ctrl_wr && !is_prescaled(new_mode)) begin
            next_prescale = 4'h0;
        end else if (rise) begin
            // switching between prescale settings keeps the count
            if (qualify) begin
                next_prescale = 4'h0;
            end else begin
                next_prescale = prescale_count + 4'h1;
            end
        end
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            prescale_count <= 4'h0;
        end else begin
            prescale_count <= next_prescale;
        end
    end

    // ****************************************
    // control register
    // ****************************************
    always @* begin
        next_mode = capture_mode_select;
        if (ctrl_wr) begin
            next_mode = new_mode;
        end
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            capture_mode_select <= `ICU_MODE_RESET;
        end else begin
            capture_mode_select <= next_mode;
        end
    end

    // ****************************************
    // timer select
    // ****************************************
    // 1 picks the third timer
    always @* begin
        next_timer_select = timer_select;
        if (tsel_wr) begin
            next_timer_select = i_avs_writedata[`ICU_TSEL_BIT];
        end
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            timer_select <= `ICU_TSEL_RESET;
        end else begin
            timer_select <= next_timer_select;
        end
    end

    // ****************************************
    // interrupt enable
    // ****************************************
    always @* begin
        next_irq_enable = capture_irq_enable;
        if (enable_wr) begin
            next_irq_enable = i_avs_writedata[0];
        end
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            capture_irq_enable <= 1'b0;
        end else begin
            capture_irq_enable <= next_irq_enable;
        end
    end

    // ****************************************
    // capture value
    // ****************************************
    always @* begin
        next_value = capture_value_pair;
        if (qualify) begin
            // old value lost without warning
            next_value = timer_select ? i_third_timer_count : i_first_timer_count;
        end
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            capture_value_pair <= {WIDTH{1'b0}};
        end else begin
            capture_value_pair <= next_value;
        end
    end

    // ****************************************
    // event flag
    // ****************************************
    always @* begin
        next_flag = capture_event_flag;
        // set wins over a clear in the same cycle
        if (qualify || mode_glitch) begin
            next_flag = 1'b1;
        end else if (clear_wr) begin
            next_flag = 1'b0;
        end
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            capture_event_flag <= 1'b0;
        end else begin
            capture_event_flag <= next_flag;
        end
    end

    // ****************************************
    // bus acknowledge
    // ****************************************
    always @* begin
        next_ack = access;
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= next_ack;
        end
    end

    // ****************************************
    // interrupt
    // ****************************************
    // masking only hides the flag; it stays sticky underneath
    assign o_irq = capture_event_flag && capture_irq_enable;

    // ****************************************
    // read mux
    // ****************************************
    always @* begin
        next_readdata = o_avs_readdata;
        // the clear register and unmapped words read zero
        if (rd) begin
            case (word)
                `ICU_ADDR_CONTROL: begin
                    next_readdata = {28'h0, capture_mode_select};
                end
                `ICU_ADDR_TIMER3_CTRL: begin
                    next_readdata = {31'h0, timer_select};
                end
                `ICU_ADDR_VALUE: begin
                    next_readdata = {{(32-WIDTH){1'b0}}, capture_value_pair};
                end
                `ICU_ADDR_STATUS: begin
                    next_readdata = {31'h0, capture_event_flag};
                end
                `ICU_ADDR_ENABLE: begin
                    next_readdata = {31'h0, capture_irq_enable};
                end
                default: begin
                    next_readdata = 32'h0;
                end
            endcase
        end
    end

    // stands until the next read
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0;
        end else begin
            o_avs_readdata <= next_readdata;
        end
    end

endmodule // icu_capture
`default_nettype wire

// [icu_map.vh]
/*
 * register map, field positions, reset values and mode codes of the
 * input capture unit.
 * assumes it is included by the capture unit only; definitions only.
 */
// Function
// - each qualifying event copies the selected timer's 16-bit count into the value pair.
// - mode selects falling, rising, every 4th rising or every 16th rising edge.
// - capture sets the event flag; only software clears it.
// - a new capture overwrites the stored value without any overrun indication.
// - a select bit in the third timer control register picks the source timer.
// - changing the capture mode may raise a spurious flag and interrupt.
// - prescaler counter clears when module is off or capture mode is left.
// - every reset clears the prescaler counter.
// - switching between prescale settings keeps the counter and may raise the flag.
`ifndef ICU_MAP_VH
`define ICU_MAP_VH

// ****************************************
// register word indices (byte address / 4)
// ****************************************
`define ICU_ADDR_CONTROL      4'h0
`define ICU_ADDR_TIMER3_CTRL  4'h1
`define ICU_ADDR_VALUE        4'h2
`define ICU_ADDR_STATUS       4'h3
`define ICU_ADDR_CLEAR        4'h4
`define ICU_ADDR_ENABLE       4'h5

// ****************************************
// fields and reset values
// ****************************************
`define ICU_MODE_MSB          3
`define ICU_TSEL_BIT          0
`define ICU_MODE_RESET        4'h0
`define ICU_TSEL_RESET        1'b0

// ****************************************
// mode codes of the control register and prescale limits
// ****************************************
`define ICU_MODE_OFF          4'h0
`define ICU_MODE_FALL         4'h4
`define ICU_MODE_RISE         4'h5
`define ICU_MODE_RISE4        4'h6
`define ICU_MODE_RISE16       4'h7
`define ICU_PRESCALE_4        4'h3
`define ICU_PRESCALE_16       4'hf

`endif

// [icu_chk.sv]
/* port checker of the capture unit.
   assumes one clock and the hand-over register map. */
`timescale 1ns/10ps
`default_nettype none
module icu_chk (
    // clock, reset, bus
    input wire i_clock, i_rst, i_avs_read, i_avs_write,
    input wire [5:0] i_avs_address,
    input wire [31:0] i_avs_writedata, o_avs_readdata,
    // waitrequest, pin, irq
    input wire o_avs_waitrequest, i_capture_input_pin, o_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    wire acc = !o_avs_waitrequest;
    wire [3:0] wrd = i_avs_address[5:2];
    logic [3:0] since_pin;
    // saturates so a stale pin edge never excuses a late flag
    always @(posedge i_clock or posedge i_rst)
        if (i_rst) since_pin <= 4'hf;
        else if ($changed(i_capture_input_pin)) since_pin <= 4'h0;
        else if (since_pin != 4'hf) since_pin <= since_pin + 4'h1;
    property p_wrd; $rose(i_avs_read) |-> o_avs_waitrequest ##1 acc; endproperty
    a_wrd: assert property (p_wrd) else $error("read wait");
    property p_wwr; $rose(i_avs_write) |-> o_avs_waitrequest ##1 acc; endproperty
    a_wwr: assert property (p_wwr) else $error("write wait");
    property p_stand; !i_avs_read |=> $stable(o_avs_readdata); endproperty
    a_stand: assert property (p_stand) else $error("readdata moved");
    property p_unm; i_avs_read && acc && (wrd == 4'h4 || wrd > 4'h5) |-> o_avs_readdata == 32'h0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_flag; i_avs_read && acc && wrd == 4'h3 && $past(o_irq) |-> o_avs_readdata[0];
    endproperty
    a_flag: assert property (p_flag) else $error("flag lost");
    property p_hold; o_irq && !i_avs_write |=> o_irq; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped");
    property p_mask; i_avs_write && acc && wrd == 4'h5 && !i_avs_writedata[0] |=> !o_irq;
    endproperty
    a_mask: assert property (p_mask) else $error("irq not masked");
    property p_cause; $rose(o_irq) |-> $past(i_avs_write) || since_pin < 4'h8; endproperty
    a_cause: assert property (p_cause) else $error("irq without cause");
    c_irq: cover property ($rose(o_irq));
    c_clr: cover property (i_avs_write && acc && wrd == 4'h4);
    c_flag: cover property (i_avs_read && acc && wrd == 4'h3 && o_avs_readdata[0]);
endmodule // icu_chk
bind icu_capture icu_chk chk_u (.i_clock(i_clock), .i_rst(i_rst), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_address(i_avs_address), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_capture_input_pin(i_capture_input_pin), .o_irq(o_irq));
`default_nettype wire

// [icu_pin_model.sv]
/* external source on the capture pin.
   assumes the bench calls pulse() between bus cycles. */
`timescale 1ns/10ps
`default_nettype none
module icu_pin_model (
    input wire logic i_clock,
    output logic o_pin
);
    initial o_pin = 1'b0;
    // edges follow a clock edge, like a timer-mode source
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge i_clock) o_pin <= 1'b1;
            repeat (3) @(posedge i_clock);
            o_pin <= 1'b0;
            repeat (3) @(posedge i_clock);
        end
        repeat (6) @(posedge i_clock);
    endtask
endmodule // icu_pin_model
`default_nettype wire

// [test_input_capture_unit.sv]
/* bench of the capture unit: bus task and scenario tasks.
   assumes the pin model and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module test_input_capture_unit;
    logic i_clock = 1'b0, i_rst = 1'b1, rd = 1'b0, wr = 1'b0, wt, irq, pin;
    logic [5:0] adr = 6'h0;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [15:0] t1 = 16'h1234, t3 = 16'h0000;
    int err_total = 0, total_checks = 0, cyc = 0;
    always #20 i_clock = ~i_clock;
    icu_capture dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wt), .i_first_timer_count(t1), .i_third_timer_count(t3),
        .i_capture_input_pin(pin), .o_irq(irq));
    icu_pin_model pin_u (.i_clock(i_clock), .o_pin(pin));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            $display("MISMATCH timeout expected %0d seen %0d", 2999, cyc);
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one request; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        rd <= !w;
        wr <= w;
        adr <= {a, 2'b00};
        wd <= d;
        do @(posedge i_clock); while (wt !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic flag(input logic e);
        bus(1'b0, 4'h3, 32'h0);
        chk("flag", {31'h0, e}, q);
    endtask
    task automatic irqv(input logic e);
        @(negedge i_clock);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task automatic s_capture;
        bus(1'b0, 4'h9, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, 4'h0, 32'h5);
        pin_u.pulse(1);
        flag(1'b1);
        bus(1'b0, 4'h2, 32'h0);
        chk("value", {16'h0, t1}, q);
        t1 <= 16'h0f0f;
        pin_u.pulse(1);
        bus(1'b0, 4'h2, 32'h0);
        chk("overwrite", 32'h0f0f, q);
        bus(1'b0, 4'h0, 32'h0);
        chk("mode", 32'h5, q);
        bus(1'b1, 4'h1, 32'h1);
        bus(1'b0, 4'h1, 32'h0);
        chk("select", 32'h1, q);
        bus(1'b1, 4'h4, 32'h1);
        flag(1'b0);
        bus(1'b1, 4'h0, 32'h4);
        flag(1'b1);
        bus(1'b1, 4'h4, 32'h1);
        t3 <= 16'hbeef;
        pin_u.pulse(1);
        bus(1'b0, 4'h2, 32'h0);
        chk("third", 32'hbeef, q);
    endtask
    task automatic s_prescale;
        bus(1'b1, 4'h4, 32'h1);
        bus(1'b1, 4'h0, 32'h0);
        bus(1'b1, 4'h0, 32'h6);
        pin_u.pulse(3);
        flag(1'b0);
        pin_u.pulse(1);
        flag(1'b1);
        bus(1'b1, 4'h4, 32'h1);
        pin_u.pulse(2);
        bus(1'b1, 4'h0, 32'h7);
        flag(1'b1);
        bus(1'b1, 4'h4, 32'h1);
        pin_u.pulse(13);
        flag(1'b0);
        pin_u.pulse(1);
        flag(1'b1);
        bus(1'b1, 4'h4, 32'h1);
        pin_u.pulse(2);
        bus(1'b1, 4'h0, 32'h0);
        bus(1'b1, 4'h0, 32'h7);
        pin_u.pulse(15);
        flag(1'b0);
        pin_u.pulse(1);
        flag(1'b1);
    endtask
    task automatic s_irq;
        bus(1'b1, 4'h4, 32'h1);
        bus(1'b1, 4'h5, 32'h1);
        irqv(1'b0);
        pin_u.pulse(16);
        irqv(1'b1);
        bus(1'b1, 4'h5, 32'h0);
        irqv(1'b0);
        bus(1'b1, 4'h5, 32'h1);
        irqv(1'b1);
        flag(1'b1);
        bus(1'b0, 4'h5, 32'h0);
        chk("enable", 32'h1, q);
        bus(1'b1, 4'h4, 32'h1);
        irqv(1'b0);
    endtask
    initial begin
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        s_capture();
        s_prescale();
        s_irq();
        finish_test();
    end
endmodule // test_input_capture_unit
`default_nettype wire
